// *** core/nip_defs.vh ***
// Purpose: Constants for the node identity and PHY register access block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz hclk
// Notes:   Offsets are byte addresses within the block
`ifndef NIP_DEFS_VH
`define NIP_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NIP_OFS_NODE_ID      8'he8
`define NIP_OFS_PHY_ACCESS   8'hec
`define NIP_OFS_IRQ_STATUS   8'hf8
`define NIP_OFS_IRQ_MASK     8'hfc

// ----------------------------------------
// Node identity fields
// ----------------------------------------
`define NIP_NID_VALID_BIT    31
`define NIP_NID_ROOT_BIT     30
`define NIP_NID_CPOWER_BIT   27
`define NIP_NID_SEG_HI       15
`define NIP_NID_SEG_LO       6
`define NIP_NID_NODE_HI      5
`define NIP_NID_NODE_LO      0
`define NIP_SEG_RESET        10'h3ff
`define NIP_NODE_RESET       6'h3f

// ----------------------------------------
// PHY access fields
// ----------------------------------------
`define NIP_PA_DONE_BIT      31
`define NIP_PA_RBIDX_HI      27
`define NIP_PA_RBIDX_LO      24
`define NIP_PA_RVAL_HI       23
`define NIP_PA_RVAL_LO       16
`define NIP_PA_RD_BIT        15
`define NIP_PA_WR_BIT        14
`define NIP_PA_TIDX_HI       11
`define NIP_PA_TIDX_LO       8
`define NIP_PA_WVAL_HI       7
`define NIP_PA_WVAL_LO       0

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define NIP_IRQ_READ_DONE    0
`define NIP_IRQ_NODE_VALID   1
`define NIP_IRQ_BUS_RESET    2
`define NIP_IRQ_WIDTH        3

`endif

// *** core/nip_sync3.v ***
// Purpose: Three-stage synchroniser with agreement of the last two stages
// Assumes: Input is asynchronous to hclk
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps

module nip_sync3
(
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  input  wire ce,
  // Data
  input  wire din,
  output reg  dout
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ----------------------------------------
  // Synchroniser chain
  // ----------------------------------------
  // Stage one feeds stage two only
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end

endmodule

// *** core/nip_regs.v ***
// Purpose: Node identity and PHY register access registers on AHB-Lite
// Assumes: One AHB-Lite master, single word transfers, zero wait states
// Notes:   PHY side is a simple request/answer port on hclk
//
// Overview of operation
// [R1] - The node identity is the 10-bit bus segment above the 6-bit PHY node index.
// [R2] - The valid flag clears on bus reset and sets when the PHY delivers a new node number.
// [R3] - The root bit is set during bus reset processing when the PHY reports root.
// [R4] - The cable power flag follows the PHY cable power status being good.
// [R5] - Node identity bits 29 to 28 and 26 to 16 read as zero.
// [R6] - The bus segment field is software writable and resets to all ones.
// [R7] - After self identification the node index loads the PHY supplied number.
// [R8] - Software must not run the transmit DMA contexts while the node index is 63.
// [R9] - The read complete flag clears on a new request and sets on a PHY register transfer.
// [R10] - The readback index captures the address of the latest PHY register transfer.
// [R11] - The read value holds the data returned by the PHY register read.
// [R12] - Software sets the read request bit and hardware clears it once sent.
// [R13] - Software sets the write request bit and hardware clears it once sent.
// [R14] - Software must never set both request bits in one write.
// [R15] - The target index serves reads and writes, the write value goes out on writes only.
// [R16] - PHY access bits 30 to 28 and 13 to 12 read as zero.
// [R17] - One request is outstanding at a time and a double request serves only the read.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "nip_defs.vh"

module nip_regs
(
  // Clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        hready,
  // PHY status pins (asynchronous)
  input  wire        phy_bus_reset,
  input  wire        phy_cable_power,
  // PHY node report (hclk domain)
  input  wire        phy_selfid_done,
  input  wire [5:0]  phy_node_number,
  input  wire        phy_is_root,
  // PHY register request (hclk domain)
  output reg         phy_req_valid,
  output reg         phy_req_write,
  output reg  [3:0]  phy_req_index,
  output reg  [7:0]  phy_req_value,
  input  wire        phy_req_ready,
  // PHY register transfer received
  input  wire        phy_xfer_valid,
  input  wire [3:0]  phy_xfer_index,
  input  wire [7:0]  phy_xfer_value,
  // Interrupt
  output reg         irq
);

  // ----------------------------------------
  // Request state machine codes
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [9:0]  bus_segment_id_reg;
  reg [5:0]  phy_node_index_reg;
  reg        node_number_valid_reg;
  reg        root_reg;
  reg        phy_read_complete_reg;
  reg [3:0]  phy_readback_index_reg;
  reg [7:0]  phy_read_value_reg;
  reg        phy_read_request_reg;
  reg        phy_write_request_reg;
  reg [3:0]  phy_target_index_reg;
  reg [7:0]  phy_write_value_reg;
  reg [`NIP_IRQ_WIDTH-1:0] irq_status_reg;
  reg [`NIP_IRQ_WIDTH-1:0] irq_mask_reg;
  reg [1:0]  state_reg;
  reg        bus_reset_d_reg;
  reg        dp_write_reg;
  reg [7:0]  dp_addr_reg;

  wire       bus_reset_s;
  wire       cable_power_ok;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Bus reset level from the PHY
  nip_sync3 u_sync_reset
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     (phy_bus_reset),
    .dout    (bus_reset_s)
  );

  // Cable power status from the PHY
  nip_sync3 u_sync_cpower
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     (phy_cable_power),
    .dout    (cable_power_ok)
  );

  // ----------------------------------------
  // Read data assembly
  // ----------------------------------------
  function [31:0] read_word;
    input [7:0] addr;
    begin
      read_word = 32'h0000_0000;
      case (addr)
        `NIP_OFS_NODE_ID:
        begin
          read_word[`NIP_NID_VALID_BIT]                    = node_number_valid_reg;
          read_word[`NIP_NID_ROOT_BIT]                     = root_reg;
          read_word[`NIP_NID_CPOWER_BIT]                   = cable_power_ok;      // [R4]
          read_word[`NIP_NID_SEG_HI:`NIP_NID_SEG_LO]       = bus_segment_id_reg;  // [R1]
          read_word[`NIP_NID_NODE_HI:`NIP_NID_NODE_LO]     = phy_node_index_reg;  // [R1]
        end                                                                      // [R5]
        `NIP_OFS_PHY_ACCESS:
        begin
          read_word[`NIP_PA_DONE_BIT]                      = phy_read_complete_reg;
          read_word[`NIP_PA_RBIDX_HI:`NIP_PA_RBIDX_LO]     = phy_readback_index_reg;
          read_word[`NIP_PA_RVAL_HI:`NIP_PA_RVAL_LO]       = phy_read_value_reg;
          read_word[`NIP_PA_RD_BIT]                        = phy_read_request_reg;
          read_word[`NIP_PA_WR_BIT]                        = phy_write_request_reg;
          read_word[`NIP_PA_TIDX_HI:`NIP_PA_TIDX_LO]       = phy_target_index_reg;
          read_word[`NIP_PA_WVAL_HI:`NIP_PA_WVAL_LO]       = phy_write_value_reg;
        end                                                                      // [R16]
        `NIP_OFS_IRQ_STATUS:
          read_word[`NIP_IRQ_WIDTH-1:0] = irq_status_reg;
        `NIP_OFS_IRQ_MASK:
          read_word[`NIP_IRQ_WIDTH-1:0] = irq_mask_reg;
        default:
          read_word = 32'h0000_0000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Field extraction shared by register and request paths
  // ----------------------------------------
  // Target index of a write to the access register
  function [3:0] target_index;
    input [31:0] word;
    begin
      target_index = word[`NIP_PA_TIDX_HI:`NIP_PA_TIDX_LO];
    end
  endfunction

  // Write value of a write to the access register
  function [7:0] write_value;
    input [31:0] word;
    begin
      write_value = word[`NIP_PA_WVAL_HI:`NIP_PA_WVAL_LO];
    end
  endfunction

  // ----------------------------------------
  // Bus decode and events
  // ----------------------------------------
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_pa      = dp_write_reg & (dp_addr_reg == `NIP_OFS_PHY_ACCESS);
  wire wr_nid     = dp_write_reg & (dp_addr_reg == `NIP_OFS_NODE_ID);
  wire wr_sts     = dp_write_reg & (dp_addr_reg == `NIP_OFS_IRQ_STATUS);
  wire wr_msk     = dp_write_reg & (dp_addr_reg == `NIP_OFS_IRQ_MASK);
  wire new_rd     = wr_pa & hwdata[`NIP_PA_RD_BIT];
  wire new_wr     = wr_pa & hwdata[`NIP_PA_WR_BIT] & ~hwdata[`NIP_PA_RD_BIT]; // [R17]
  wire reset_rise = bus_reset_s & ~bus_reset_d_reg;
  wire sent       = (state_reg == ST_SEND) & phy_req_valid & phy_req_ready;
  // Either request bit still set means one request is outstanding
  wire req_busy   = phy_read_request_reg | phy_write_request_reg;
  wire [`NIP_IRQ_WIDTH-1:0] irq_events;

  assign irq_events = {reset_rise, phy_selfid_done, phy_xfer_valid};

  // ----------------------------------------
  // AHB-Lite slave, zero wait states, OKAY
  // ----------------------------------------
  // Read word is built in the address phase, so a read right behind a
  // write to the same register returns the old contents
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
    else if (ce)
    begin
      dp_write_reg <= addr_phase & hwrite;
      if (addr_phase)
        dp_addr_reg <= haddr;
      if (addr_phase & ~hwrite)
        hrdata <= read_word(haddr);
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Node identity register
  // ----------------------------------------
  // Node index keeps its last value across a bus reset until the next
  // self identification, which wins over a bus reset edge in one cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_segment_id_reg    <= `NIP_SEG_RESET;
      phy_node_index_reg    <= `NIP_NODE_RESET;
      node_number_valid_reg <= 1'b0;
      root_reg              <= 1'b0;
      bus_reset_d_reg       <= 1'b0;
    end
    else if (ce)
    begin
      bus_reset_d_reg <= bus_reset_s;
      if (wr_nid)
        bus_segment_id_reg <= hwdata[`NIP_NID_SEG_HI:`NIP_NID_SEG_LO]; // [R6]
      if (phy_selfid_done)
      begin
        phy_node_index_reg    <= phy_node_number;                     // [R7]
        node_number_valid_reg <= 1'b1;                                // [R2]
      end
      else if (reset_rise)
        node_number_valid_reg <= 1'b0;                                // [R2]
      if (bus_reset_s)
        root_reg <= phy_is_root;                                      // [R3]
    end
  end

  // ----------------------------------------
  // PHY access register and request engine
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phy_read_complete_reg  <= 1'b0;
      phy_readback_index_reg <= 4'h0;
      phy_read_value_reg     <= 8'h00;
      phy_read_request_reg   <= 1'b0;
      phy_write_request_reg  <= 1'b0;
      phy_target_index_reg   <= 4'h0;
      phy_write_value_reg    <= 8'h00;
      state_reg              <= ST_IDLE;
      phy_req_valid          <= 1'b0;
      phy_req_write          <= 1'b0;
      phy_req_index          <= 4'h0;
      phy_req_value          <= 8'h00;
    end
    else if (ce)
    begin
      // Arriving transfer wins over a clear in the same cycle
      if (phy_xfer_valid)
      begin
        phy_read_complete_reg  <= 1'b1;                               // [R9]
        phy_readback_index_reg <= phy_xfer_index;                     // [R10]
        phy_read_value_reg     <= phy_xfer_value;                     // [R11]
      end
      else if (new_rd | new_wr)
        phy_read_complete_reg <= 1'b0;                                // [R9]
      // Index and value are stored even while a request is outstanding
      if (wr_pa)
      begin
        phy_target_index_reg <= target_index(hwdata);
        phy_write_value_reg  <= write_value(hwdata);
      end
      case (state_reg)
        ST_IDLE:
        begin
          // New requests only while nothing is outstanding
          if (new_rd & ~req_busy)
          begin
            phy_read_request_reg <= 1'b1;                             // [R12]
            phy_req_valid        <= 1'b1;
            phy_req_write        <= 1'b0;
            phy_req_index        <= target_index(hwdata);             // [R15]
            phy_req_value        <= 8'h00;                            // [R15]
            state_reg            <= ST_SEND;
          end
          else if (new_wr & ~req_busy)
          begin
            phy_write_request_reg <= 1'b1;                            // [R13]
            phy_req_valid         <= 1'b1;
            phy_req_write         <= 1'b1;
            phy_req_index         <= target_index(hwdata);            // [R15]
            phy_req_value         <= write_value(hwdata);             // [R15]
            state_reg             <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          // Request fields stand until the PHY takes them
          if (sent)
          begin
            phy_read_request_reg  <= 1'b0;                            // [R12]
            phy_write_request_reg <= 1'b0;                            // [R13]
            phy_req_valid         <= 1'b0;
            state_reg             <= ST_IDLE;                         // [R17]
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status_reg <= {`NIP_IRQ_WIDTH{1'b0}};
      irq_mask_reg   <= {`NIP_IRQ_WIDTH{1'b0}};
      irq            <= 1'b0;
    end
    else if (ce)
    begin
      // Set wins over write-one-to-clear
      irq_status_reg <= (irq_status_reg & ~(wr_sts ? hwdata[`NIP_IRQ_WIDTH-1:0] : {`NIP_IRQ_WIDTH{1'b0}}))
                        | irq_events;
      if (wr_msk)
        irq_mask_reg <= hwdata[`NIP_IRQ_WIDTH-1:0];
      // Output follows the masked status one cycle late
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule

// *** tb/nip_regs_asserts.sv ***
// Purpose: Port assertions for the node id and PHY access block
// Assumes: Zero wait reads, hready tied to hreadyout
// Notes:   Bound to nip_regs, sees its ports only
`timescale 1ns/1ps

module nip_regs_asserts
(
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // AHB side
  input wire        hsel,
  input wire        hready,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // PHY side
  input wire        phy_selfid_done,
  input wire [5:0]  phy_node_number,
  input wire        phy_req_valid,
  input wire        phy_req_write,
  input wire [3:0]  phy_req_index,
  input wire [7:0]  phy_req_value,
  input wire        phy_req_ready,
  input wire        phy_xfer_valid,
  input wire [3:0]  phy_xfer_index,
  input wire [7:0]  phy_xfer_value
);
  // ----------
  // Checks
  // ----------
  // Address phase decode of the two registers
  wire take   = hsel && hready && htrans[1];
  wire rd_nid = take && !hwrite && haddr == 8'he8;
  wire rd_pa  = take && !hwrite && haddr == 8'hec;
  wire wr_pa  = take && hwrite && haddr == 8'hec;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_req_holds:
    assert property (phy_req_valid && !phy_req_ready |=> phy_req_valid && $stable(phy_req_index))
      else $error("request moved before ready");
  a_req_drop:
    assert property (phy_req_valid && phy_req_ready |=> !phy_req_valid)
      else $error("request still pending after ready");
  a_req_start:
    assert property (wr_pa && !phy_req_valid ##1 (hwdata[15] || hwdata[14]) && !phy_req_valid |=> phy_req_valid
      && phy_req_write == !$past(hwdata[15]) && phy_req_index == $past(hwdata[11:8])
      && (!phy_req_write || phy_req_value == $past(hwdata[7:0]))) else $error("request not issued as written");
  a_rd_zero:
    assert property (phy_req_valid && !phy_req_write |-> phy_req_value == 8'h00)
      else $error("read request carries a value");
  a_nid_resv:
    assert property (rd_nid |=> hrdata[29:28] == 2'b00 && hrdata[26:16] == 11'h000)
      else $error("node id reserved bits set");
  a_pa_resv:
    assert property (rd_pa |=> hrdata[30:28] == 3'b000 && hrdata[13:12] == 2'b00)
      else $error("access reserved bits set");
  a_xfer_load:
    assert property (phy_xfer_valid ##1 rd_pa |=> hrdata[31] && hrdata[27:16] ==
      {$past(phy_xfer_index, 2), $past(phy_xfer_value, 2)}) else $error("transfer not captured");
  a_node_load:
    assert property (phy_selfid_done ##1 rd_nid |=> hrdata[31] && hrdata[5:0] == $past(phy_node_number, 2))
      else $error("node number not loaded");
endmodule

bind nip_regs nip_regs_asserts chk (.*);

// *** tb/nip_phy_model.sv ***
// Purpose: Behavioural PHY layer answering register requests
// Assumes: Requests held until ready, one outstanding
// Notes:   Stall input sets how slowly requests are accepted
`timescale 1ns/1ps

module nip_phy_model
(
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Pacing
  input  wire [3:0] stall,
  // Request from the link
  input  wire       phy_req_valid,
  input  wire       phy_req_write,
  input  wire [3:0] phy_req_index,
  input  wire [7:0] phy_req_value,
  output reg        phy_req_ready,
  // Register transfer to the link
  output reg        phy_xfer_valid,
  output reg  [3:0] phy_xfer_index,
  output reg  [7:0] phy_xfer_value
);
  // ----------
  // Model
  // ----------
  reg [7:0] regs [0:15];
  reg [3:0] wait_cnt;
  reg [3:0] rd_idx;
  reg [1:0] gap;
  integer   i;
  // Accept after a stall, answer reads two cycles later
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phy_req_ready  <= 1'b0;
      phy_xfer_valid <= 1'b0;
      phy_xfer_index <= 4'h0;
      phy_xfer_value <= 8'h00;
      wait_cnt       <= 4'h0;
      rd_idx         <= 4'h0;
      gap            <= 2'd0;
      for (i = 0; i < 16; i = i + 1)
        regs[i] <= i[7:0] ^ 8'h5a;
    end
    else
    begin
      phy_xfer_valid <= 1'b0;
      phy_xfer_index <= ~phy_xfer_index; // No stale data between transfers
      phy_xfer_value <= ~phy_xfer_value;
      phy_req_ready  <= 1'b0;
      wait_cnt       <= phy_req_valid ? wait_cnt + 4'h1 : 4'h0;
      if (phy_req_valid && !phy_req_ready && wait_cnt >= stall)
        phy_req_ready <= 1'b1;
      if (phy_req_valid && phy_req_ready)
      begin
        wait_cnt <= 4'h0;
        if (phy_req_write)
          regs[phy_req_index] <= phy_req_value;
        else
        begin
          rd_idx <= phy_req_index;
          gap    <= 2'd2;
        end
      end
      if (gap != 2'd0)
        gap <= gap - 2'd1;
      if (gap == 2'd1)
      begin
        phy_xfer_valid <= 1'b1;
        phy_xfer_index <= rd_idx;
        phy_xfer_value <= regs[rd_idx];
      end
    end
  end
endmodule

// *** tb/tb_node_id_and_phy_reg_access.sv ***
// Purpose: Bench for the node id and PHY access registers
// Assumes: PHY model answers requests, hready is hreadyout
// Notes:   Fixed seed random traffic plus corner cases
`timescale 1ns/1ps

module tb_node_id_and_phy_reg_access;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
  // ----------
  // Bench
  // ----------
  reg         hclk = 0, hresetn = 0, ce = 1, hsel = 1, hwrite = 0, phy_bus_reset = 0, phy_cable_power = 1;
  reg         phy_selfid_done = 0, phy_is_root = 0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'b00;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0, rd, cmd;
  reg  [5:0]  phy_node_number = 6'h00;
  reg  [3:0]  stall = 4'h4, idx;
  reg  [7:0]  wv, mirror [0:15];
  reg  [11:0] last_rb = 12'h000;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, irq, phy_req_valid, phy_req_write, phy_req_ready, phy_xfer_valid;
  wire [3:0]  phy_req_index, phy_xfer_index;
  wire [7:0]  phy_req_value, phy_xfer_value;
  integer     seed, err_total, compares, k;
  nip_regs uut (.*, .hready(hreadyout));
  nip_phy_model phy (.*);
  // Clock
  initial
  begin
    forever #5 hclk = ~hclk;
  end
  // Expected node identity word
  function [31:0] nid(input r, input c, input [9:0] s, input [5:0] n);
    nid = {1'b1, r, 2'b00, c, 11'h000, s, n};
  endfunction
  // One AHB-Lite single transfer, read data left in rd
  task ahb(input w, input [7:0] a, input [31:0] d);
  begin
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (!hreadyout)
      @(posedge hclk);
    htrans <= 2'b00;
    if (w)
      hwdata <= d;
    @(posedge hclk);
    while (!hreadyout)
      @(posedge hclk);
    rd = hrdata;
  end
  endtask
  // PHY request: 0 read, 1 write, 2 both bits
  task phy_op(input integer o, input same);
  begin
    cmd = $random(seed);
    if (!same)
      idx = cmd[11:8];
    cmd[11:8] = idx;
    wv = cmd[7:0];
    stall <= cmd[30:28] + 4'h4;
    cmd[15] = (o != 1); // Both bits when o is 2, in the deliberate double case and in the random traffic
    cmd[14] = (o != 0);
    ahb(1, 8'hec, cmd);
    ahb(0, 8'hec, 0);
    `CHK(rd[31], 1'b0)
    `CHK(rd[15], cmd[15])
    do
      ahb(0, 8'hec, 0);
    while (o == 1 ? rd[14] !== 1'b0 : rd[31] !== 1'b1);
    if (o != 1)
      last_rb = {idx, mirror[idx]};
    else
      mirror[idx] = wv;
    `CHK(rd, {o != 1, 3'b000, last_rb, 4'h0, idx, wv})
  end
  endtask
  // Counts and verdict
  task report_and_stop;
  begin
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    seed = 32'hc2b5cd44;
    err_total = 0;
    compares = 0;
    for (k = 0; k < 16; k++)
      mirror[k] = k[7:0] ^ 8'h5a;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    ahb(0, 8'he8, 0);
    `CHK(rd, 32'h0800ffff)
    ahb(0, 8'hec, 0);
    `CHK(rd, 32'h0)
    ahb(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
    // Bus reset, segment write, new node number
    for (k = 0; k < 3; k++)
    begin
      cmd = $random(seed);
      phy_node_number <= (k == 2) ? 6'h3f : cmd[21:16]; // Index 63 starts no transmit context here
      phy_is_root <= k[0];
      phy_cable_power <= k[1];
      phy_bus_reset <= 1'b1;
      repeat (8) @(posedge hclk);
      ahb(0, 8'he8, 0);
      `CHK(rd[31:30], {1'b0, k[0]})
      phy_bus_reset <= 1'b0;
      ahb(1, 8'he8, cmd);
      repeat (8) @(posedge hclk);
      phy_selfid_done <= 1'b1;
      @(posedge hclk);
      phy_selfid_done <= 1'b0;
      ahb(0, 8'he8, 0);
      `CHK(rd, nid(k[0], k[1], cmd[15:6], phy_node_number))
    end
    // Write, read back, double request, read back, then random
    phy_op(1, 0);
    phy_op(0, 1);
    phy_op(2, 1);
    phy_op(0, 1);
    for (k = 0; k < 12; k++)
      phy_op($unsigned($random(seed)) % 3, 0);
    // Interrupt masked, raised, cleared
    ahb(1, 8'hfc, 32'h0);
    ahb(1, 8'hf8, 32'h7);
    phy_op(0, 1);
    `CHK(irq, 1'b0)
    ahb(1, 8'hfc, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b1)
    ahb(0, 8'hf8, 0);
    `CHK(rd, 32'h1)
    ahb(1, 8'hf8, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0)
    // Clock enable low freezes the node report
    ahb(0, 8'he8, 0);
    cmd = rd;
    ce <= 1'b0;
    phy_node_number <= ~phy_node_number;
    phy_selfid_done <= 1'b1;
    repeat (2) @(posedge hclk);
    ce <= 1'b1;
    phy_selfid_done <= 1'b0;
    @(posedge hclk);
    ahb(0, 8'he8, 0);
    `CHK(rd, cmd)
    report_and_stop;
  end
endmodule
